// ---- verilog/lsw_pkg.sv ----
package lsw_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int POINTS    = 32;
    localparam int PT_W      = 5;
    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 32;
    localparam int SLOT_W    = 3;
    localparam int TBL_AW    = PT_W + SLOT_W;
    localparam int TBL_DEPTH = 256;
    localparam int VAL_W     = 64;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_LIMIT_OUT = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_REFUSED   = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_AMP_SEL_A = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_AMP_SEL_B = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_AMP_SEL_C = 12'h014;
    localparam int                TBL_SEL_BIT   = 10;

    // ------------------------------------------------------------------
    // Point table slots, byte offset 0x400 + point*0x20 + slot*4
    // ------------------------------------------------------------------
    localparam logic [SLOT_W-1:0] SLOT_CFG     = 3'h0;
    localparam logic [SLOT_W-1:0] SLOT_ON_LO   = 3'h1;
    localparam logic [SLOT_W-1:0] SLOT_ON_HI   = 3'h2;
    localparam logic [SLOT_W-1:0] SLOT_OFF_LO  = 3'h3;
    localparam logic [SLOT_W-1:0] SLOT_OFF_HI  = 3'h4;
    localparam logic [SLOT_W-1:0] SLOT_EVAL    = 3'h5;

    // ------------------------------------------------------------------
    // Point configuration word fields
    // ------------------------------------------------------------------
    localparam int CFG_TGT_LSB = 0;
    localparam int CFG_PROT    = 5;
    localparam int CFG_SRC_LSB = 6;
    localparam int CFG_TYP_LSB = 11;
    localparam int CFG_EN_ASN  = 13;
    localparam int CFG_EN_LSB  = 14;
    localparam int CFG_FRC_ASN = 19;
    localparam int CFG_FRC_LSB = 20;
    localparam int CFG_USED    = 25;

    // ------------------------------------------------------------------
    // Status bits and reset values
    // ------------------------------------------------------------------
    localparam int ST_READY = 0;
    localparam int ST_VALID = 1;
    localparam int ST_BUSY  = 2;

    localparam logic [15:0] AMP_SEL_A_RST = 16'h0005;
    localparam logic [15:0] AMP_SEL_B_RST = 16'h0004;
    localparam logic [15:0] AMP_SEL_C_RST = 16'h0003;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TYPE_I16 = 2'b00,
        TYPE_I32 = 2'b01,
        TYPE_F64 = 2'b10
    } lsw_type_e;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_RUN  = 2'b01
    } lsw_scan_e;

endpackage : lsw_pkg

// ---- verilog/lsw_table_mem.sv ----
`timescale 1ns/1ps

module lsw_table_mem #(
    parameter int W     = 32,
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    // Clock
    input  wire logic              i_clk,
    // Write port
    input  wire logic              i_we,
    input  wire logic [AW-1:0]     i_waddr,
    input  wire logic [W-1:0]      i_wdata,
    input  wire logic [W/8-1:0]    i_wstrb,
    // Read port
    input  wire logic [AW-1:0]     i_raddr,
    output logic      [W-1:0]      o_rdata
);

    logic [W-1:0] mem [DEPTH];

    // ------------------------------------------------------------------
    // Byte lanes
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        for (int b = 0; b < W/8; b++) begin
            if (i_we && i_wstrb[b]) begin
                mem[i_waddr][b*8 +: 8] <= i_wdata[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        o_rdata <= mem[i_raddr];
    end

endmodule : lsw_table_mem

// ---- verilog/lsw_limit_outputs.sv ----
// Behaviour
// - Thirty-two independent points, up to 32 watched axes.
// - Thresholds and watch compared as signed.
// - ON below OFF: on <= watch < off.
// - ON above OFF: watch >= on or < off.
// - Equal thresholds keep the point off.
// - Evaluate only while processor ready follows host.
// - Host ready falling clears every limit output.
// - Capture thresholds at ready rise, refresh per cycle.
// - Points sharing a target are ORed.
// - Assigned enable bit gates window control.
// - No enable bit means always enabled.
// - Force bit asserts output, overrides enable.
// - No force bit means never forced.
// - Window, enable, force results ORed per target.
// - Watch types: int16, int32, float64.
// - Amplifier selects default to 5, 4, 3.
// - Protected input image targets are refused.
`timescale 1ns/1ps

module lsw_limit_outputs #(
    parameter int N_WATCH = 32
) (
    // Clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    // Host bit devices
    input  wire logic                        i_host_ready_flag,
    input  wire logic [lsw_pkg::POINTS-1:0]  i_enable_bits,
    input  wire logic [lsw_pkg::POINTS-1:0]  i_force_bits,
    // Motion side
    input  wire logic                        i_op_cycle,
    input  wire logic [N_WATCH*64-1:0]       i_watch_data,
    // Outputs
    output logic                             o_motion_proc_ready_flag,
    output logic      [lsw_pkg::POINTS-1:0]  o_limit_out,
    output logic      [15:0]                 o_amp_output_select_a,
    output logic      [15:0]                 o_amp_output_select_b,
    output logic      [15:0]                 o_amp_output_select_c,
    // AXI4-Lite write channels
    input  wire logic                        i_s_axi_awvalid,
    output logic                             o_s_axi_awready,
    input  wire logic [lsw_pkg::ADDR_W-1:0]  i_s_axi_awaddr,
    input  wire logic                        i_s_axi_wvalid,
    output logic                             o_s_axi_wready,
    input  wire logic [31:0]                 i_s_axi_wdata,
    input  wire logic [3:0]                  i_s_axi_wstrb,
    output logic                             o_s_axi_bvalid,
    input  wire logic                        i_s_axi_bready,
    output logic      [1:0]                  o_s_axi_bresp,
    // AXI4-Lite read channels
    input  wire logic                        i_s_axi_arvalid,
    output logic                             o_s_axi_arready,
    input  wire logic [lsw_pkg::ADDR_W-1:0]  i_s_axi_araddr,
    output logic                             o_s_axi_rvalid,
    input  wire logic                        i_s_axi_rready,
    output logic      [31:0]                 o_s_axi_rdata,
    output logic      [1:0]                  o_s_axi_rresp
);

    // ------------------------------------------------------------------
    // Comparison key
    // ------------------------------------------------------------------
    // Maps each type onto an unsigned order so that one comparator serves
    // all three. Floats ignore NaN and treat -0 below +0.
    function automatic logic [63:0] cmp_key(input logic [1:0] t, input logic [63:0] v);
        case (t)
            lsw_pkg::TYPE_I16: cmp_key = {~v[15], {48{v[15]}}, v[14:0]};
            lsw_pkg::TYPE_F64: cmp_key = v[63] ? ~v : {1'b1, v[62:0]};
            default:           cmp_key = {~v[31], {32{v[31]}}, v[30:0]};
        endcase
    endfunction : cmp_key

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic                       rdy_s1;
    logic                       rdy_s2;
    logic [lsw_pkg::POINTS-1:0] en_s1;
    logic [lsw_pkg::POINTS-1:0] en_s2;
    logic [lsw_pkg::POINTS-1:0] frc_s1;
    logic [lsw_pkg::POINTS-1:0] frc_s2;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
            en_s1  <= '0;
            en_s2  <= '0;
            frc_s1 <= '0;
            frc_s2 <= '0;
        end else begin
            rdy_s1 <= i_host_ready_flag;
            rdy_s2 <= rdy_s1;
            en_s1  <= i_enable_bits;
            en_s2  <= en_s1;
            frc_s1 <= i_force_bits;
            frc_s2 <= frc_s1;
        end
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    lsw_pkg::lsw_scan_e           state;
    lsw_pkg::lsw_scan_e           next_state;
    logic [lsw_pkg::PT_W-1:0]     pt;
    logic [lsw_pkg::SLOT_W-1:0]   slot;
    logic                         pend;
    logic                         out_valid;
    logic [lsw_pkg::POINTS-1:0]   acc;
    logic [lsw_pkg::POINTS-1:0]   refused;
    logic [31:0]                  cfg;
    logic [31:0]                  on_lo;
    logic [31:0]                  on_hi;
    logic [31:0]                  off_lo;
    logic [31:0]                  mem_rdata;
    logic                         aw_held;
    logic                         w_held;
    logic [lsw_pkg::ADDR_W-1:0]   aw_addr;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;
    logic                         rd_mem;

    // ------------------------------------------------------------------
    // Ready flag and scan trigger
    // ------------------------------------------------------------------
    wire ready_rise = rdy_s2 & ~o_motion_proc_ready_flag;
    wire running    = (state == lsw_pkg::SCAN_RUN);
    wire start      = (state == lsw_pkg::SCAN_IDLE) & o_motion_proc_ready_flag & pend;
    wire last_slot  = (slot == lsw_pkg::SLOT_EVAL);
    wire last_pt    = (pt == lsw_pkg::PT_W'(lsw_pkg::POINTS - 1));
    wire scan_done  = running & last_slot & last_pt;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_motion_proc_ready_flag <= 1'b0;
            pend                     <= 1'b0;
        end else begin
            o_motion_proc_ready_flag <= rdy_s2;
            if (ready_rise || (i_op_cycle && rdy_s2)) begin
                pend <= 1'b1;
            end else if (start || !rdy_s2) begin
                pend <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Scan state machine
    // ------------------------------------------------------------------
    always_comb begin
        case (state)
            lsw_pkg::SCAN_IDLE: next_state = start ? lsw_pkg::SCAN_RUN : lsw_pkg::SCAN_IDLE;
            lsw_pkg::SCAN_RUN: begin
                if (!o_motion_proc_ready_flag || scan_done) begin
                    next_state = lsw_pkg::SCAN_IDLE;
                end else begin
                    next_state = lsw_pkg::SCAN_RUN;
                end
            end
            default: next_state = lsw_pkg::SCAN_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= lsw_pkg::SCAN_IDLE;
            pt    <= '0;
            slot  <= '0;
        end else begin
            state <= next_state;
            if (!running) begin
                pt   <= '0;
                slot <= '0;
            end else if (last_slot) begin
                pt   <= pt + 1'b1;
                slot <= '0;
            end else begin
                slot <= slot + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Point table
    // ------------------------------------------------------------------
    // The table is the host's word-device image; every scan rereads it,
    // so the first scan after ready rising is the capture and each later
    // scan is the per-cycle refresh. Reads stall while a scan runs.
    wire                       tbl_we    = aw_held & w_held & ~o_s_axi_bvalid
                                           & aw_addr[lsw_pkg::TBL_SEL_BIT];
    wire [lsw_pkg::TBL_AW-1:0] tbl_raddr = running ? {pt, slot}
                                                   : i_s_axi_araddr[9:2];

    lsw_table_mem #(
        .W     (32),
        .DEPTH (lsw_pkg::TBL_DEPTH),
        .AW    (lsw_pkg::TBL_AW)
    ) u_table (
        .i_clk   (i_clk),
        .i_we    (tbl_we),
        .i_waddr (aw_addr[9:2]),
        .i_wdata (w_data),
        .i_wstrb (w_strb),
        .i_raddr (tbl_raddr),
        .o_rdata (mem_rdata)
    );

    always_ff @(posedge i_clk) begin
        if (running && slot == 3'h1) cfg    <= mem_rdata;
        if (running && slot == 3'h2) on_lo  <= mem_rdata;
        if (running && slot == 3'h3) on_hi  <= mem_rdata;
        if (running && slot == 3'h4) off_lo <= mem_rdata;
    end

    // ------------------------------------------------------------------
    // Point evaluation
    // ------------------------------------------------------------------
    wire [4:0]  cfg_tgt = cfg[lsw_pkg::CFG_TGT_LSB +: 5];
    wire [4:0]  cfg_src = cfg[lsw_pkg::CFG_SRC_LSB +: 5];
    wire [1:0]  cfg_typ = cfg[lsw_pkg::CFG_TYP_LSB +: 2];
    wire [4:0]  cfg_en  = cfg[lsw_pkg::CFG_EN_LSB +: 5];
    wire [4:0]  cfg_frc = cfg[lsw_pkg::CFG_FRC_LSB +: 5];
    wire        used    = cfg[lsw_pkg::CFG_USED];
    wire        prot    = cfg[lsw_pkg::CFG_PROT];
    wire        src_ok  = (int'(cfg_src) < N_WATCH);
    wire [63:0] watch   = src_ok ? i_watch_data[cfg_src*64 +: 64] : 64'h0;

    wire [63:0] k_on    = cmp_key(cfg_typ, {on_hi, on_lo});
    wire [63:0] k_off   = cmp_key(cfg_typ, {mem_rdata, off_lo});
    wire [63:0] k_w     = cmp_key(cfg_typ, watch);
    wire        ge_on   = (k_w >= k_on);
    wire        lt_off  = (k_w < k_off);
    wire        win     = (k_on < k_off) ? (ge_on & lt_off) :
                          (k_on > k_off) ? (ge_on | lt_off) :
                          1'b0;
    wire        en_ok   = ~cfg[lsw_pkg::CFG_EN_ASN] | en_s2[cfg_en];
    wire        forced  = cfg[lsw_pkg::CFG_FRC_ASN] & frc_s2[cfg_frc];
    wire        result  = used & ~prot & (forced | (en_ok & win));
    wire [31:0] hit     = result ? (32'h1 << cfg_tgt) : 32'h0;
    wire [31:0] next_acc = acc | hit;

    // Outputs change only at the end of a whole scan or when ready drops, so that a target
    // shared by several points never shows a partial OR.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            acc         <= '0;
            o_limit_out <= '0;
            out_valid   <= 1'b0;
            refused     <= '0;
        end else if (!rdy_s2 || !o_motion_proc_ready_flag) begin
            acc         <= '0;
            o_limit_out <= '0;
            out_valid   <= 1'b0;
        end else if (running && last_slot) begin
            acc          <= last_pt ? 32'h0 : next_acc;
            refused[pt]  <= used & prot;
            if (last_pt) begin
                o_limit_out <= next_acc;
                out_valid   <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    wire wr_go   = aw_held & w_held & ~o_s_axi_bvalid;
    wire wr_reg  = ~aw_addr[lsw_pkg::TBL_SEL_BIT];
    wire wr_a    = wr_go & wr_reg & (aw_addr == lsw_pkg::OFS_AMP_SEL_A);
    wire wr_b    = wr_go & wr_reg & (aw_addr == lsw_pkg::OFS_AMP_SEL_B);
    wire wr_c    = wr_go & wr_reg & (aw_addr == lsw_pkg::OFS_AMP_SEL_C);
    wire wr_ro   = (aw_addr == lsw_pkg::OFS_STATUS) | (aw_addr == lsw_pkg::OFS_LIMIT_OUT)
                   | (aw_addr == lsw_pkg::OFS_REFUSED);
    wire wr_map  = ~wr_reg | wr_ro | (aw_addr == lsw_pkg::OFS_AMP_SEL_A)
                   | (aw_addr == lsw_pkg::OFS_AMP_SEL_B) | (aw_addr == lsw_pkg::OFS_AMP_SEL_C);
    wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [15:0] amp_wr = w_data[15:0] & wmask;

    assign o_s_axi_awready = ~aw_held & ~o_s_axi_bvalid;
    assign o_s_axi_wready  = ~w_held & ~o_s_axi_bvalid;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end else begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {i_s_axi_awaddr[lsw_pkg::ADDR_W-1:2], 2'b00};
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= i_s_axi_wdata;
                w_strb <= i_s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_s_axi_bvalid        <= 1'b0;
            o_s_axi_bresp         <= lsw_pkg::RESP_OKAY;
            o_amp_output_select_a <= lsw_pkg::AMP_SEL_A_RST;
            o_amp_output_select_b <= lsw_pkg::AMP_SEL_B_RST;
            o_amp_output_select_c <= lsw_pkg::AMP_SEL_C_RST;
        end else begin
            if (wr_go) begin
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= wr_map ? lsw_pkg::RESP_OKAY : lsw_pkg::RESP_SLVERR;
            end else if (i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
            if (wr_a) o_amp_output_select_a <= (o_amp_output_select_a & ~wmask) | amp_wr;
            if (wr_b) o_amp_output_select_b <= (o_amp_output_select_b & ~wmask) | amp_wr;
            if (wr_c) o_amp_output_select_c <= (o_amp_output_select_c & ~wmask) | amp_wr;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    wire        ar_take = i_s_axi_arvalid & o_s_axi_arready;
    wire        ar_tbl  = i_s_axi_araddr[lsw_pkg::TBL_SEL_BIT];
    wire [lsw_pkg::ADDR_W-1:0] ar_a = {i_s_axi_araddr[lsw_pkg::ADDR_W-1:2], 2'b00};
    wire [31:0] st_word = {29'h0, running, out_valid, o_motion_proc_ready_flag};
    wire [31:0] reg_rd  =
        (ar_a == lsw_pkg::OFS_STATUS)    ? st_word :
        (ar_a == lsw_pkg::OFS_LIMIT_OUT) ? o_limit_out :
        (ar_a == lsw_pkg::OFS_REFUSED)   ? refused :
        (ar_a == lsw_pkg::OFS_AMP_SEL_A) ? {16'h0, o_amp_output_select_a} :
        (ar_a == lsw_pkg::OFS_AMP_SEL_B) ? {16'h0, o_amp_output_select_b} :
        (ar_a == lsw_pkg::OFS_AMP_SEL_C) ? {16'h0, o_amp_output_select_c} : 32'h0;
    wire        reg_hit = (ar_a <= lsw_pkg::OFS_AMP_SEL_C);

    assign o_s_axi_arready = ~o_s_axi_rvalid & ~rd_mem & ~running;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_mem         <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= '0;
            o_s_axi_rresp  <= lsw_pkg::RESP_OKAY;
        end else begin
            rd_mem <= ar_take & ar_tbl;
            if (rd_mem) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata  <= mem_rdata;
                o_s_axi_rresp  <= lsw_pkg::RESP_OKAY;
            end else if (ar_take && !ar_tbl) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata  <= reg_rd;
                o_s_axi_rresp  <= reg_hit ? lsw_pkg::RESP_OKAY : lsw_pkg::RESP_SLVERR;
            end else if (i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : lsw_limit_outputs

// ---- tb/lsw_limit_outputs_asserts.sv ----
`timescale 1ns/1ps
module lsw_chk (
    input wire logic        i_clk, i_rst, i_host_ready_flag, o_motion_proc_ready_flag,
    input wire logic [31:0] o_limit_out, o_s_axi_rdata,
    input wire logic [15:0] o_amp_output_select_a, o_amp_output_select_b, o_amp_output_select_c,
    input wire logic        i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready,
    input wire logic        o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready,
    input wire logic        o_s_axi_rvalid, i_s_axi_rready
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    reset_vals_a: assert property ($fell(i_rst) |-> o_amp_output_select_a == 16'h0005 &&
        o_amp_output_select_b == 16'h0004 && o_amp_output_select_c == 16'h0003) else $error("bad reset");
    ready_follow_a: assert property ($rose(i_host_ready_flag) ##1 i_host_ready_flag[*2] |=>
        o_motion_proc_ready_flag) else $error("ready late");
    ready_drop_a: assert property ($fell(i_host_ready_flag) ##1 !i_host_ready_flag[*2] |=>
        !o_motion_proc_ready_flag && o_limit_out == 32'h0) else $error("ready stuck");
    idle_clear_a: assert property (!o_motion_proc_ready_flag |-> o_limit_out == 32'h0)
        else $error("output while idle");
    first_scan_a: assert property ($rose(o_motion_proc_ready_flag) |->
        (o_limit_out == 32'h0)[*8]) else $error("output before scan");
    wr_resp_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid &&
        o_s_axi_wready |-> ##2 o_s_axi_bvalid) else $error("no write response");
    rd_resp_a: assert property (i_s_axi_arvalid && o_s_axi_arready |-> ##[1:2] o_s_axi_rvalid)
        else $error("no read response");
    rdata_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
        o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped");
    busy_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("write taken early");
    cover property ($rose(o_limit_out[0]));
    cover property (o_s_axi_bvalid && i_s_axi_bready);
    cover property ($fell(o_motion_proc_ready_flag));
endmodule : lsw_chk
bind lsw_limit_outputs lsw_chk u_chk (.i_clk, .i_rst, .i_host_ready_flag,
    .o_motion_proc_ready_flag, .o_limit_out, .o_s_axi_rdata, .o_amp_output_select_a,
    .o_amp_output_select_b, .o_amp_output_select_c, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rvalid, .i_s_axi_rready);

// ---- tb/lsw_host_model.sv ----
`timescale 1ns/1ps
module lsw_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_ready_req,
    input  wire logic [31:0] i_en_req,
    input  wire logic [31:0] i_frc_req,
    output logic             o_host_ready_flag,
    output logic      [31:0] o_enable_bits,
    output logic      [31:0] o_force_bits
);
    // A scanned program updates its bit devices only on a rising clock edge, never mid-edge.
    always_ff @(posedge i_clk) begin
        o_host_ready_flag <= i_ready_req;
        o_enable_bits     <= i_en_req;
        o_force_bits      <= i_frc_req;
    end
endmodule : lsw_host_model

// ---- tb/limit_switch_window_outputs_tb_top.sv ----
`timescale 1ns/1ps
module limit_switch_window_outputs_tb_top;
    logic          i_clk = 1'b0, i_rst = 1'b1, rq = 1'b0, op = 1'b0, h_rdy, mrdy;
    logic [31:0]   en_q = '0, fr_q = '0, h_en, h_fr, lim, wd = '0, rdat, d;
    logic [2047:0] watch = '0;
    logic          awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic          awr, wrr, bv, arr, rv;
    logic [11:0]   awa = '0, ara = '0;
    logic [3:0]    ws = 4'hf;
    logic [1:0]    br, rr, r;
    int            fails = 0, n_checks = 0, cyc = 0;
    always #12.5 i_clk = ~i_clk;
    lsw_host_model u_host (.i_clk(i_clk), .i_ready_req(rq), .i_en_req(en_q), .i_frc_req(fr_q),
        .o_host_ready_flag(h_rdy), .o_enable_bits(h_en), .o_force_bits(h_fr));
    lsw_limit_outputs u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_host_ready_flag(h_rdy),
        .i_enable_bits(h_en), .i_force_bits(h_fr), .i_op_cycle(op), .i_watch_data(watch),
        .o_motion_proc_ready_flag(mrdy), .o_limit_out(lim), .o_amp_output_select_a(),
        .o_amp_output_select_b(), .o_amp_output_select_c(), .i_s_axi_awvalid(awv),
        .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrr),
        .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre),
        .o_s_axi_bresp(br), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
        .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    // Handshakes are sampled at the falling edge so that no race with the rising edge arises.
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(negedge i_clk);
            ta = awr;
            tw = wrr;
            tb = bv;
            r = br;
            @(posedge i_clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!tb);
        bre <= 1'b0;
        @(posedge i_clk);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        logic ta, tr;
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(negedge i_clk);
            ta = arr;
            tr = rv;
            d = rdat;
            r = rr;
            @(posedge i_clk);
            if (ta) arv <= 1'b0;
        end while (!tr);
        rre <= 1'b0;
        @(posedge i_clk);
    endtask : rd
    task automatic wp(input int p, input logic [31:0] c, input logic [31:0] on, off);
        logic [11:0] b;
        b = 12'h400 + 12'(p * 32);
        wr(b, c);
        wr(b + 12'h004, on);
        wr(b + 12'h008, {32{on[31]}});
        wr(b + 12'h00c, off);
        wr(b + 12'h010, {32{off[31]}});
    endtask : wp
    task automatic scan_chk(input logic [31:0] exp);
        while (mrdy !== 1'b1) @(posedge i_clk);
        repeat (250) @(posedge i_clk);
        @(negedge i_clk);
        chk(lim, exp);
        @(posedge i_clk);
    endtask : scan_chk
    task automatic t_regs();
        for (int i = 0; i < 3; i++) begin
            rd(12'h00c + 12'(4 * i));
            chk(d, 32'(5 - i));
        end
        wr(12'h00c, 32'h0000_1234);
        rd(12'h00c);
        chk(d, 32'h0000_1234);
        rd(12'h0f0);
        chk({30'h0, r}, 32'h2);
        wr(12'h0f0, 32'h0);
        chk({30'h0, r}, 32'h2);
        i_rst <= 1'b1;
        @(posedge i_clk);
        i_rst <= 1'b0;
        rd(12'h00c);
        chk(d, 32'h5);
    endtask : t_regs
    task automatic t_windows();
        for (int p = 7; p < 32; p++) wr(12'h400 + 12'(p * 32), 32'h0);
        wp(0, 32'h0200_0800, 32'hffff_fffb, 32'd5);
        wp(1, 32'h0200_0041, 32'h0001_000a, 32'hffff_fff6);
        wp(2, 32'h0200_0802, 32'd3, 32'd3);
        wp(3, 32'h0239_2803, 32'd0, 32'd100);
        wp(4, 32'h0201_6804, 32'hffff_fff6, 32'd0);
        wp(5, 32'h0200_0825, 32'hffff_fff6, 32'd0);
        wp(6, 32'h0200_1040, 32'd15, 32'd25);
        watch[127:0] <= {64'h14, 64'hffff_ffff_ffff_fffb};
        fr_q <= 32'h8;
        rq <= 1'b1;
        scan_chk(32'h0000_000b);
        rd(12'h008);
        chk(d, 32'h20);
        fr_q <= 32'h0;
        en_q <= 32'h20;
        wp(0, 32'h0200_0800, 32'd0, 32'd5);
        wp(1, 32'h0200_0841, 32'd7, 32'd7);
        op <= 1'b1;
        @(posedge i_clk);
        op <= 1'b0;
        scan_chk(32'h0000_0011);
    endtask : t_windows
    task automatic t_drop();
        rq <= 1'b0;
        while (mrdy !== 1'b0) @(posedge i_clk);
        @(negedge i_clk);
        chk(lim, 32'h0);
        @(posedge i_clk);
        rd(12'h000);
        chk(d & 32'h1, 32'h0);
    endtask : t_drop
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_regs();
        t_windows();
        t_drop();
        end_sim();
    end
endmodule : limit_switch_window_outputs_tb_top
